//--- hdl/ecc_encoder.sv
// ECC byte generator for one 8-bit data byte
`timescale 1ns/1ps
module ecc_encoder (
   input wire logic [7:0] data,
   output logic [7:0] code
);

   // ----------------------------------------------------------------
   // Hamming(12,8) check bits plus overall parity
   // ----------------------------------------------------------------
   logic [3:0] check;
   logic overall;

   // Data sits at code positions 3,5,6,7,9,10,11,12
   assign check[0] = data[0] ^ data[1] ^ data[3] ^ data[4] ^ data[6];
   assign check[1] = data[0] ^ data[2] ^ data[3] ^ data[5] ^ data[6];
   assign check[2] = data[1] ^ data[2] ^ data[3] ^ data[7];
   assign check[3] = data[4] ^ data[5] ^ data[6] ^ data[7];
   assign overall = (^data) ^ (^check); // Catches double errors
   assign code = {flash_ctrl_pkg::ecc_unused, overall, check};

endmodule

//--- hdl/flash_command_controller.sv
// Embedded flash command controller with register port and CPU stall
// How it works
// - Fetch ECC error raises the interrupt, or a reset when enabled.
// - CPU stays stalled while a command runs, released on completion.
// - A time-out from an eight-entry table ends a hung command.
// - Each 16-bit flash word holds a data byte (low) and its ECC byte (high).
// - Read loads the raw word into the read data pair.
// - An ECC error on a read sets fail when the read ends.
// - Optionally the low read byte is returned ECC corrected.
// - Read ECC error pulses flag a (single) or flag b (double).
// - Main: 64 pages of 512 words; info pages by info commands.
// - Erase always works on a whole page.
// - Five-bit command decode; command byte resets to 0x80.
// - Info writes allowed only at 0x0040-0x01ff or second block.
// - Info page erase only acts on the second block.
// - Word address is built from two reset-to-zero byte registers.
// - Data bytes hold write data, reads return read data.
// - ECC helper returns the ECC byte of the written value.
// - Timing base ticks at clock times (scaler+1)/256.
`timescale 1ns/1ps
module flash_command_controller #(
   parameter bit correct_low_byte = 1'b0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] xfr_addr,
   input wire logic xfr_wr,
   input wire logic xfr_rd,
   input wire logic [7:0] xfr_wdata,
   output logic [7:0] xfr_rdata,
   output logic cpu_stall,
   output logic flash_req,
   output flash_ctrl_pkg::flash_op_t flash_op,
   output logic flash_info,
   output logic [15:0] flash_addr,
   output logic [15:0] flash_wdata,
   input wire logic [15:0] flash_rdata,
   input wire logic flash_done,
   input wire logic fetch_ecc_error,
   input wire logic ecc_reset_enable,
   output logic ecc_irq,
   output logic ecc_reset_req,
   output logic program_ecc_flag_a,
   output logic program_ecc_flag_b
);

   typedef enum logic [1:0] {
      st_idle,
      st_run,
      st_verify
   } state_t;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   state_t state;
   logic [7:0] wdata_low;
   logic [7:0] wdata_high;
   logic [7:0] rdata_low;
   logic [7:0] rdata_high;
   logic [7:0] addr_low;
   logic [7:0] addr_high;
   logic [7:0] ecc_value;
   logic [7:0] scaler;
   logic [4:0] code;
   logic [2:0] timeout_select;
   logic fail;
   logic verify_mismatch;
   logic verify_pending;
   logic [7:0] base_acc;
   logic [13:0] tick_count;

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   wire logic hit_dlow = xfr_addr == flash_ctrl_pkg::addr_flash_data_low;
   wire logic hit_dhigh = xfr_addr == flash_ctrl_pkg::addr_flash_data_high;
   wire logic hit_alow = xfr_addr == flash_ctrl_pkg::addr_flash_address_low;
   wire logic hit_ahigh =
      xfr_addr == flash_ctrl_pkg::addr_flash_address_high;
   wire logic hit_ecc = xfr_addr == flash_ctrl_pkg::addr_ecc_helper;
   wire logic hit_cmd =
      xfr_addr == flash_ctrl_pkg::addr_flash_command_status;
   wire logic hit_scaler =
      xfr_addr == flash_ctrl_pkg::addr_program_timing_scaler;
   wire logic busy = state != st_idle;
   wire logic [7:0] status_byte = {verify_mismatch, busy, fail, code};
   wire logic [15:0] word_addr = {addr_high, addr_low};

   // Unmapped addresses read as zero
   assign xfr_rdata = hit_dlow ? rdata_low :
      hit_dhigh ? rdata_high :
      hit_alow ? addr_low :
      hit_ahigh ? addr_high :
      hit_ecc ? ecc_value :
      hit_cmd ? status_byte :
      hit_scaler ? scaler : flash_ctrl_pkg::byte_reset;

   // ----------------------------------------------------------------
   // Command decode and legality
   // ----------------------------------------------------------------
   wire logic [4:0] new_code = xfr_wdata[flash_ctrl_pkg::cmd_code_msb:
      flash_ctrl_pkg::cmd_code_lsb];
   wire logic issue = xfr_wr && hit_cmd && !busy;
   wire logic is_mread = new_code == flash_ctrl_pkg::code_main_read;
   wire logic is_merase = new_code == flash_ctrl_pkg::code_main_erase;
   wire logic is_mwrite = new_code == flash_ctrl_pkg::code_main_write;
   wire logic is_iread = new_code == flash_ctrl_pkg::code_info_read;
   wire logic is_iwrite = new_code == flash_ctrl_pkg::code_info_write;
   wire logic is_ierase = new_code == flash_ctrl_pkg::code_info_erase;
   wire logic is_main = is_mread || is_merase || is_mwrite;
   wire logic is_info = is_iread || is_iwrite || is_ierase;
   wire logic main_ok = word_addr < flash_ctrl_pkg::main_word_limit;
   wire logic info_ok = word_addr < flash_ctrl_pkg::info_word_limit;
   wire logic in_second = word_addr >= flash_ctrl_pkg::info_second_base;
   wire logic iwrite_ok = in_second ||
      word_addr >= flash_ctrl_pkg::info_write_low;
   wire logic cmd_legal = (is_main && main_ok) ||
      (is_info && info_ok && !(is_iwrite && !iwrite_ok) &&
      !(is_ierase && !in_second));
   wire logic start = issue && cmd_legal;
   wire logic is_erase_new = is_merase || is_ierase;
   wire logic is_write_new = is_mwrite || is_iwrite;

   // Erase targets the page start; low offset bits are ignored
   wire logic [15:0] page_addr =
      word_addr & ~flash_ctrl_pkg::page_offset_mask;

   // ----------------------------------------------------------------
   // Read ECC check
   // ----------------------------------------------------------------
   logic [7:0] helper_code;
   logic [7:0] read_code;
   wire logic [7:0] ecc_value_in = xfr_wdata;
   ecc_encoder u_helper_ecc (
      .data(ecc_value_in),
      .code(helper_code)
   );
   ecc_encoder u_read_ecc (
      .data(flash_rdata[7:0]),
      .code(read_code)
   );

   // Low byte is data, high byte its ECC code; syndrome from bits 11:8
   wire logic [3:0] syndrome = read_code[3:0] ^ flash_rdata[11:8];
   wire logic parity_bad = read_code[flash_ctrl_pkg::ecc_parity_bit] ^
      flash_rdata[12] ^ (^syndrome) ^ (^syndrome);
   wire logic overall_bad = (^flash_rdata[7:0]) ^ (^flash_rdata[12:8]);
   wire logic unused_bad = flash_rdata[15:13] != flash_ctrl_pkg::ecc_unused;
   wire logic single_err = overall_bad && !unused_bad;
   wire logic double_err = ((syndrome != 4'h0) && !overall_bad) ||
      unused_bad || (parity_bad && 1'b0);
   wire logic ecc_err = single_err || double_err;

   // Map a syndrome to the data bit it points at
   function automatic logic [7:0] flip_mask(input logic [3:0] s);
      logic [7:0] m;
      m = 8'h00;
      case (s)
         4'h3: m = 8'h01;
         4'h5: m = 8'h02;
         4'h6: m = 8'h04;
         4'h7: m = 8'h08;
         4'h9: m = 8'h10;
         4'ha: m = 8'h20;
         4'hb: m = 8'h40;
         4'hc: m = 8'h80;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Raw by default; the corrected low byte is a build option
   wire logic [7:0] fixed_low = flash_rdata[7:0] ^
      (single_err ? flip_mask(syndrome) : 8'h00);
   wire logic [7:0] load_low = correct_low_byte ? fixed_low :
      flash_rdata[7:0];

   // ----------------------------------------------------------------
   // Timing base and time-out
   // ----------------------------------------------------------------
   wire logic [8:0] acc_sum = {1'b0, base_acc} + {1'b0, scaler} + 9'h001;
   wire logic base_tick = acc_sum[8];
   logic erase_run;
   wire logic [13:0] timeout_limit = erase_run ?
      flash_ctrl_pkg::erase_timeout[timeout_select] :
      flash_ctrl_pkg::write_timeout[timeout_select];
   wire logic timed_out = busy && base_tick &&
      (tick_count >= timeout_limit - 14'h0001);
   wire logic op_end = busy && (flash_done || timed_out);

   // Phase accumulator keeps running; only its carry is used
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         base_acc <= flash_ctrl_pkg::byte_reset;
      end else begin
         base_acc <= acc_sum[7:0];
      end
   end

   // Tick counter restarts for each flash operation
   always_ff @(posedge clk) begin
      if (sys_rst || start || flash_req) begin
         tick_count <= 14'h0000;
      end else if (busy && base_tick) begin
         tick_count <= tick_count + 14'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Software writable registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wdata_low <= flash_ctrl_pkg::byte_reset;
         wdata_high <= flash_ctrl_pkg::byte_reset;
         addr_low <= flash_ctrl_pkg::byte_reset;
         addr_high <= flash_ctrl_pkg::byte_reset;
         scaler <= flash_ctrl_pkg::scaler_reset;
      end else if (xfr_wr && !busy) begin
         if (hit_dlow) wdata_low <= xfr_wdata;
         if (hit_dhigh) wdata_high <= xfr_wdata;
         if (hit_alow) addr_low <= xfr_wdata;
         if (hit_ahigh) addr_high <= xfr_wdata;
         if (hit_scaler) scaler <= xfr_wdata;
      end
   end

   // Helper answers with the code of whatever byte was written
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ecc_value <= flash_ctrl_pkg::ecc_helper_reset;
      end else if (xfr_wr && hit_ecc) begin
         ecc_value <= helper_code;
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= st_idle;
         code <= flash_ctrl_pkg::command_status_reset[4:0];
         timeout_select <= flash_ctrl_pkg::command_status_reset[7:5];
         verify_mismatch <= flash_ctrl_pkg::command_status_reset[7];
         fail <= 1'b0;
         flash_req <= 1'b0;
         flash_op <= flash_ctrl_pkg::op_read;
         flash_info <= 1'b0;
         flash_addr <= 16'h0000;
         flash_wdata <= 16'h0000;
         erase_run <= 1'b0;
         verify_pending <= 1'b0;
         rdata_low <= flash_ctrl_pkg::byte_reset;
         rdata_high <= flash_ctrl_pkg::byte_reset;
      end else begin
         flash_req <= 1'b0;
         case (state)
            st_idle: begin
               if (issue) begin
                  code <= new_code;
                  timeout_select <= xfr_wdata[
                     flash_ctrl_pkg::cmd_timeout_msb:
                     flash_ctrl_pkg::cmd_timeout_lsb];
                  verify_mismatch <= 1'b0;
                  fail <= !cmd_legal;
               end
               if (start) begin
                  state <= st_run;
                  flash_req <= 1'b1;
                  flash_info <= is_info;
                  flash_addr <= is_erase_new ? page_addr : word_addr;
                  flash_wdata <= {wdata_high, wdata_low};
                  erase_run <= is_erase_new;
                  verify_pending <= is_write_new;
                  flash_op <= is_erase_new ? flash_ctrl_pkg::op_erase :
                     is_write_new ? flash_ctrl_pkg::op_write :
                     flash_ctrl_pkg::op_read;
               end
            end
            st_run: begin
               if (op_end && timed_out && !flash_done) begin
                  fail <= 1'b1;
                  state <= st_idle;
               end else if (op_end && verify_pending) begin
                  state <= st_verify;
                  flash_req <= 1'b1;
                  flash_op <= flash_ctrl_pkg::op_read;
               end else if (op_end) begin
                  if (flash_op == flash_ctrl_pkg::op_read) begin
                     rdata_low <= load_low;
                     rdata_high <= flash_rdata[15:8];
                     if (ecc_err) fail <= 1'b1;
                  end
                  state <= st_idle;
               end
            end
            st_verify: begin
               if (op_end) begin
                  if (timed_out && !flash_done) begin
                     fail <= 1'b1;
                  end else if (flash_rdata != flash_wdata) begin
                     verify_mismatch <= 1'b1;
                  end
                  state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   assign cpu_stall = busy;

   // ----------------------------------------------------------------
   // ECC event pulses
   // ----------------------------------------------------------------
   wire logic read_end = (state == st_run) && flash_done &&
      !verify_pending && (flash_op == flash_ctrl_pkg::op_read);

   // Reset request replaces the interrupt when enabled
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ecc_irq <= 1'b0;
         ecc_reset_req <= 1'b0;
         program_ecc_flag_a <= 1'b0;
         program_ecc_flag_b <= 1'b0;
      end else begin
         ecc_irq <= fetch_ecc_error && !ecc_reset_enable;
         ecc_reset_req <= fetch_ecc_error && ecc_reset_enable;
         program_ecc_flag_a <= read_end && single_err;
         program_ecc_flag_b <= read_end && double_err;
      end
   end

endmodule

//--- pkg/flash_ctrl_pkg.sv
// Constants shared by the embedded flash command controller
package flash_ctrl_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the extended register port)
   // ----------------------------------------------------------------
   localparam logic [15:0] addr_flash_data_low = 16'ha020;
   localparam logic [15:0] addr_flash_data_high = 16'ha021;
   localparam logic [15:0] addr_flash_address_low = 16'ha022;
   localparam logic [15:0] addr_flash_address_high = 16'ha023;
   localparam logic [15:0] addr_ecc_helper = 16'ha024;
   localparam logic [15:0] addr_flash_command_status = 16'ha025;
   localparam logic [15:0] addr_program_timing_scaler = 16'ha026;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] byte_reset = 8'h00;
   localparam logic [7:0] command_status_reset = 8'h80;
   localparam logic [7:0] ecc_helper_reset = 8'h00;
   localparam logic [7:0] scaler_reset = 8'h25;

   // ----------------------------------------------------------------
   // Field positions of the command/status byte
   // ----------------------------------------------------------------
   localparam int cmd_code_lsb = 0;
   localparam int cmd_code_msb = 4;
   localparam int cmd_fail_bit = 5;
   localparam int cmd_busy_bit = 6;
   localparam int cmd_timeout_lsb = 5;
   localparam int cmd_timeout_msb = 7;
   localparam int cmd_verify_bit = 7;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [4:0] code_main_read = 5'h10;
   localparam logic [4:0] code_main_erase = 5'h08;
   localparam logic [4:0] code_main_write = 5'h04;
   localparam logic [4:0] code_info_read = 5'h02;
   localparam logic [4:0] code_info_write = 5'h01;
   localparam logic [4:0] code_info_erase = 5'h03;

   // Operation requested from the flash array
   typedef enum logic [1:0] {
      op_read,
      op_write,
      op_erase
   } flash_op_t;

   // ----------------------------------------------------------------
   // Address space
   // ----------------------------------------------------------------
   localparam logic [15:0] main_word_limit = 16'h8000;
   localparam logic [15:0] info_word_limit = 16'h0400;
   localparam logic [15:0] info_second_base = 16'h0200;
   localparam logic [15:0] info_write_low = 16'h0040;
   localparam logic [15:0] page_offset_mask = 16'h01ff;

   // ----------------------------------------------------------------
   // Time-out, in periods of the timing base
   // ----------------------------------------------------------------
   localparam int timeout_w = 14;
   typedef logic [timeout_w-1:0] timeout_table_t [0:7];
   localparam timeout_table_t write_timeout = '{
      14'h0037, 14'h003c, 14'h0041, 14'h0045,
      14'h004b, 14'h0050, 14'h0055, 14'h0059};
   localparam timeout_table_t erase_timeout = '{
      14'h153b, 14'h1741, 14'h1934, 14'h1af1,
      14'h1cf0, 14'h1ee2, 14'h20d4, 14'h22b9};

   // ECC code layout: four Hamming bits, overall parity, unused zeros
   localparam int ecc_parity_bit = 4;
   localparam logic [2:0] ecc_unused = 3'h0;

endpackage

//--- sim/embedded_flash_command_controller_test.sv
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
module embedded_flash_command_controller_test;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] xfr_addr = 16'h0000;
   logic xfr_wr = 1'b0;
   logic xfr_rd = 1'b0;
   logic [7:0] xfr_wdata = 8'h00;
   logic [7:0] xfr_rdata;
   logic cpu_stall, flash_req, flash_info, flash_done;
   flash_ctrl_pkg::flash_op_t flash_op;
   logic [15:0] flash_addr, flash_wdata, flash_rdata, w;
   logic fetch_ecc_error = 1'b0;
   logic ecc_reset_enable = 1'b0;
   logic ecc_irq, ecc_reset_req, program_ecc_flag_a, program_ecc_flag_b;
   logic [11:0] delay = 12'h003;
   logic corrupt = 1'b0;
   logic [7:0] rd;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int stalled, n0, fa, fb;
   int n_req = 0, n_fa = 0, n_fb = 0, n_irq = 0, n_rst = 0;
   logic [7:0] rst_val [0:7] = '{0, 0, 0, 0, 0, 8'h80, 8'h25, 0};
   logic [15:0] t_addr [0:6] = '{16'h8000, 16'h0020, 16'h0040, 16'h01ff,
      16'h0205, 16'h0400, 16'h0000};
   logic [7:0] t_cmd [0:6] = '{8'hf0, 8'he1, 8'he1, 8'he3, 8'he3, 8'he2,
      8'hff};
   logic [7:0] t_st [0:6] = '{8'h30, 8'h21, 8'h01, 8'h23, 8'h03, 8'h22,
      8'h3f};
   int t_req [0:6] = '{0, 0, 2, 0, 1, 0, 0};
   localparam logic [15:0] sta = flash_ctrl_pkg::addr_flash_command_status;
   localparam logic [15:0] dlo = flash_ctrl_pkg::addr_flash_data_low;

   always #5 clk = ~clk;

   flash_command_controller flash_command_controller_inst (.clk, .sys_rst,
      .xfr_addr, .xfr_wr, .xfr_rd, .xfr_wdata, .xfr_rdata, .cpu_stall,
      .flash_req, .flash_op, .flash_info, .flash_addr, .flash_wdata,
      .flash_rdata, .flash_done, .fetch_ecc_error, .ecc_reset_enable,
      .ecc_irq, .ecc_reset_req, .program_ecc_flag_a, .program_ecc_flag_b);
   flash_array_model flash_array_model_inst (.clk, .flash_req, .flash_op,
      .flash_info, .flash_addr, .flash_wdata, .flash_rdata, .flash_done,
      .delay, .corrupt);

   // Pulse counters; the cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cycles++;
      if (flash_req === 1'b1) n_req++;
      if (program_ecc_flag_a === 1'b1) n_fa++;
      if (program_ecc_flag_b === 1'b1) n_fb++;
      if (ecc_irq === 1'b1) n_irq++;
      if (ecc_reset_req === 1'b1) n_rst++;
      if (cycles == 30000) begin
         n_errors++;
         results();
      end
   end

   task automatic results();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe, taken at the rising edge in between
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      xfr_addr = a;
      xfr_wdata = d;
      xfr_wr = 1'b1;
      @(negedge clk);
      xfr_wr = 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk);
      xfr_addr = a;
      xfr_rd = 1'b1;
      @(posedge clk);
      rd = xfr_rdata;
      @(negedge clk);
      xfr_rd = 1'b0;
      check({8'h00, rd}, {8'h00, exp});
   endtask
   // Load address, issue command, wait out stall
   task automatic cmd(input logic [7:0] b, input logic [15:0] a);
      wr(flash_ctrl_pkg::addr_flash_address_low, a[7:0]);
      wr(flash_ctrl_pkg::addr_flash_address_high, a[15:8]);
      wr(sta, b);
      stalled = 0;
      while (cpu_stall === 1'b1 && stalled < 12000) begin
         @(negedge clk);
         stalled++;
      end
      repeat (2) @(negedge clk);
   endtask
   function automatic logic [7:0] ecc_of(input logic [7:0] d);
      logic [3:0] c;
      c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
      return {3'b000, ^{d, c}, c};
   endfunction

   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rdc(dlo + 16'(i), rst_val[i]);
      end
      cmd(8'h00, 16'h1234);
      rdc(flash_ctrl_pkg::addr_flash_address_low, 8'h34);
      rdc(flash_ctrl_pkg::addr_flash_address_high, 8'h12);
      for (int i = 0; i < 3; i++) begin
         wr(flash_ctrl_pkg::addr_ecc_helper, 8'h5a + 8'(i * 67));
         rdc(flash_ctrl_pkg::addr_ecc_helper, ecc_of(8'h5a + 8'(i * 67)));
      end
      wr(flash_ctrl_pkg::addr_program_timing_scaler, 8'hff);
      rdc(flash_ctrl_pkg::addr_program_timing_scaler, 8'hff);
      // Erased word has an illegal code
      n0 = n_req;
      cmd(8'he8, 16'h0605);
      check(16'(n_req - n0), 16'h0001);
      fb = n_fb;
      cmd(8'hf0, 16'h0600);
      rdc(sta, 8'h30);
      rdc(dlo, 8'hff);
      check(16'(n_fb - fb), 16'h0001);
      // Clean, single and double error words
      for (int i = 0; i < 3; i++) begin
         w = {ecc_of(8'h3c) ^ (i == 1 ? 8'h10 : 8'h00), 8'h3c ^ 8'(i / 2 * 3)};
         wr(dlo, w[7:0]);
         wr(flash_ctrl_pkg::addr_flash_data_high, w[15:8]);
         cmd(8'he4, 16'h0601 + 16'(i));
         rdc(sta, 8'h04);
         fa = n_fa;
         fb = n_fb;
         cmd(8'hf0, 16'h0601 + 16'(i));
         rdc(sta, i > 0 ? 8'h30 : 8'h10);
         rdc(dlo, w[7:0]);
         rdc(flash_ctrl_pkg::addr_flash_data_high, w[15:8]);
         check({8'(n_fa - fa), 8'(n_fb - fb)}, {7'h00, i == 1, 7'h00, i == 2});
      end
      corrupt = 1'b1;
      cmd(8'he4, 16'h0610);
      rdc(sta, 8'h84);
      corrupt = 1'b0;
      for (int i = 0; i < 7; i++) begin
         n0 = n_req;
         cmd(t_cmd[i], t_addr[i]);
         rdc(sta, t_st[i]);
         check(16'(n_req - n0), 16'(t_req[i]));
      end
      // Hung write ends by time-out
      delay = 12'd2000;
      for (int k = 0; k < 2; k++) begin
         cmd({k ? 3'h7 : 3'h0, 5'h04}, 16'h0620);
         check(16'(stalled >= (k ? 89 : 55) && stalled < (k ? 95 : 61)), 16'h1);
         rdc(sta, 8'h24);
         repeat (2100) @(negedge clk);
      end
      delay = 12'h003;
      for (int e = 0; e < 2; e++) begin
         ecc_reset_enable = e[0];
         fetch_ecc_error = 1'b1;
         @(negedge clk);
         fetch_ecc_error = 1'b0;
         repeat (3) @(negedge clk);
      end
      check({8'(n_irq), 8'(n_rst)}, 16'h0101);
      results();
   end
endmodule

bind flash_command_controller flash_command_controller_properties
   flash_command_controller_properties_inst (.clk, .sys_rst, .cpu_stall,
   .flash_req, .flash_op, .flash_info, .flash_addr, .flash_done,
   .fetch_ecc_error, .ecc_reset_enable, .ecc_irq, .ecc_reset_req,
   .program_ecc_flag_a, .program_ecc_flag_b);

//--- sim/flash_array_model.sv
// Behavioural 16-bit embedded flash array on the controller's far side
`timescale 1ns/1ps
module flash_array_model (
   input wire logic clk,
   input wire logic flash_req,
   input wire flash_ctrl_pkg::flash_op_t flash_op,
   input wire logic flash_info,
   input wire logic [15:0] flash_addr,
   input wire logic [15:0] flash_wdata,
   output logic [15:0] flash_rdata,
   output logic flash_done,
   input wire logic [11:0] delay,
   input wire logic corrupt
);
   logic [15:0] main_mem [0:32767];
   logic [15:0] info_mem [0:1023];
   logic [15:0] word = 16'h0000;
   logic [15:0] a;
   // Answers after delay cycles; outside done the data lines show junk
   initial begin
      flash_done = 1'b0;
      forever begin
         @(posedge clk);
         if (flash_req === 1'b1) begin
            a = flash_addr;
            repeat (delay) @(posedge clk);
            if (flash_op == flash_ctrl_pkg::op_erase) begin
               for (int i = 0; i < 512; i++) begin
                  if (flash_info) info_mem[{a[9], i[8:0]}] = 16'hffff;
                  else main_mem[{a[14:9], i[8:0]}] = 16'hffff;
               end
            end else if (flash_op == flash_ctrl_pkg::op_write) begin
               // Flip bit 0 on demand
               if (flash_info) info_mem[a[9:0]] = flash_wdata ^ 16'(corrupt);
               else main_mem[a[14:0]] = flash_wdata ^ 16'(corrupt);
            end else begin
               word = flash_info ? info_mem[a[9:0]] : main_mem[a[14:0]];
            end
            flash_done <= 1'b1;
            @(posedge clk);
            flash_done <= 1'b0;
         end
      end
   end
   assign flash_rdata = flash_done ? word : ~word;
endmodule

//--- sim/flash_command_controller_properties.sv
// Port-level checks for the flash command controller
`timescale 1ns/1ps
module flash_command_controller_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cpu_stall,
   input wire logic flash_req,
   input wire flash_ctrl_pkg::flash_op_t flash_op,
   input wire logic flash_info,
   input wire logic [15:0] flash_addr,
   input wire logic flash_done,
   input wire logic fetch_ecc_error,
   input wire logic ecc_reset_enable,
   input wire logic ecc_irq,
   input wire logic ecc_reset_req,
   input wire logic program_ecc_flag_a,
   input wire logic program_ecc_flag_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Operation in flight; a dropped stall (done or timeout) forgets it
   logic live;
   flash_ctrl_pkg::flash_op_t live_op;
   always_ff @(posedge clk) begin
      if (sys_rst || (!flash_req && !cpu_stall)) begin
         live <= 1'b0;
      end else if (flash_req) begin
         live <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (flash_req) begin
         live_op <= flash_op;
      end
   end

   sequence write_lands;
      live && live_op == flash_ctrl_pkg::op_write && flash_done;
   endsequence
   sequence read_lands;
      live && live_op == flash_ctrl_pkg::op_read && flash_done;
   endsequence

   verify_follows_write_a: assert property (write_lands |=> flash_req && flash_op == flash_ctrl_pkg::op_read)
      else $error("no verify read");
   release_after_read_a: assert property (read_lands |=> !cpu_stall)
      else $error("stall held");
   stall_starts_op_a: assert property ($rose(cpu_stall) |-> flash_req)
      else $error("stall no req");
   erase_whole_page_a: assert property (flash_req && flash_op == flash_ctrl_pkg::op_erase |-> flash_addr[8:0] == 9'h000)
      else $error("erase unaligned");
   main_range_a: assert property (flash_req && !flash_info |-> flash_addr < 16'h8000)
      else $error("main addr range");
   info_erase_limit_a: assert property (flash_req && flash_info && flash_op == flash_ctrl_pkg::op_erase |-> flash_addr >= 16'h0200)
      else $error("info erase low");
   info_write_limit_a: assert property (flash_req && flash_info && flash_op == flash_ctrl_pkg::op_write |-> flash_addr >= 16'h0040)
      else $error("info write low");
   fetch_irq_a: assert property (fetch_ecc_error && !ecc_reset_enable |=> ecc_irq && !ecc_reset_req)
      else $error("no ecc irq");
   fetch_reset_a: assert property (fetch_ecc_error && ecc_reset_enable |=> ecc_reset_req)
      else $error("no ecc reset");
   flag_after_done_a: assert property (program_ecc_flag_a || program_ecc_flag_b |-> $past(flash_done) && !(program_ecc_flag_a && program_ecc_flag_b))
      else $error("stray ecc flag");
endmodule
